// [hdl/tmr_cfg.svh]
/*
 Register offsets, field positions, reset values and counts of the 16-bit
 timer control slice. Assumes byte addresses on an 8-bit APB address bus.
*/
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_OFS_CR1   8'h00
`define TMR_OFS_CR2   8'h04
`define TMR_OFS_SR    8'h08
`define TMR_OFS_IC1   8'h0C
`define TMR_OFS_IC2   8'h10
`define TMR_OFS_OC1   8'h14
`define TMR_OFS_OC2   8'h18
`define TMR_OFS_CNT   8'h1C
`define TMR_OFS_ACNT  8'h20
`define TMR_B_CIE     7
`define TMR_B_OIE     6
`define TMR_B_TIE     5
`define TMR_B_FORCE_LEVEL_TWO   4
`define TMR_B_FORCE_LEVEL_ONE   3
`define TMR_B_LEVEL_TWO_BIT   2
`define TMR_B_CAPTURE_ONE_EDGE_SELECT   1
`define TMR_B_LEVEL_ONE_BIT   0
`define TMR_B_COMPARE_PIN_ONE_ENABLE    7
`define TMR_B_COMPARE_PIN_TWO_ENABLE    6
`define TMR_B_OPM     5
`define TMR_B_PWM     4
`define TMR_B_IEDG2   1
`define TMR_F_CAPTURE_ONE_FLAG    4
`define TMR_F_COMPARE_ONE_FLAG    3
`define TMR_F_TOF     2
`define TMR_F_CAPTURE_TWO_FLAG    1
`define TMR_F_COMPARE_TWO_FLAG    0
`define TMR_CR_RST    8'h00
`define TMR_DAT_RST   16'h0000
`define TMR_CNT_RST   16'hFFFC
`define TMR_OPM_CAP   16'hFFFD
`define TMR_CNT_MAX   16'hFFFF
`define TMR_DIV_LAST  2'h3
`endif

// [hdl/tmr_pkg.sv]
/*
 Types shared by the timer control slice.
 Assumes nothing of its surroundings.
*/
package tmr_pkg;
   typedef enum logic [2:0] {
      TMR_MD_NORM = 3'h1,
      TMR_MD_OPM  = 3'h2,
      TMR_MD_PWM  = 3'h4
   } tmr_mode_e;
   typedef logic [15:0] tmr_word_t;
endpackage : tmr_pkg

// [hdl/tmr_cap_if.sv]
/*
 Carrier between the timer core and one capture detector.
 Assumes both ends run on pclk.
*/
`timescale 1ns/10ps
interface tmr_cap_if;
   logic edge_rise;
   logic halt;
   logic halt_exit;
   logic fire;
   modport cap (input edge_rise, input halt, input halt_exit, output fire);
   modport ctl (output edge_rise, output halt, output halt_exit, input fire);
endinterface : tmr_cap_if

// [hdl/tmr_div.sv]
/*
 Prescaler: one-cycle count enable every fourth pclk while running.
 Assumes run comes from logic on pclk.
*/
`timescale 1ns/10ps
`include "tmr_cfg.svh"
module tmr_div (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control and tick
   input  wire logic run,
   output wire logic tick
);
   logic [1:0] div_q;

   // Halt freezes the phase too, so counting resumes exactly where it left.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 2'h0;
      end else if (run) begin
         div_q <= div_q + 2'h1;
      end
   end

   assign tick = run && (div_q == `TMR_DIV_LAST);
endmodule : tmr_div

// [hdl/tmr_capture.sv]
/*
 Capture detector: pin synchroniser, edge select, and arming during halt.
 Assumes an asynchronous pin; halt and halt_exit come from pclk logic.
*/
`timescale 1ns/10ps
module tmr_capture (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Capture pin
   input  wire logic pin,
   // Core side
   tmr_cap_if.cap    cif
);
   logic       sync1_q;
   logic       sync2_q;
   logic       prev_q;
   logic [1:0] vld_q;
   logic       armed_q;
   logic       edge_w;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 1'h0;
         sync2_q <= 1'h0;
         prev_q  <= 1'h0;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Edges are ignored for two cycles after reset; prev_q still holds reset filler one cycle longer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vld_q <= 2'h0;
      end else if (!vld_q[1]) begin
         vld_q <= {vld_q[0], 1'h1};
      end
   end

   assign edge_w = vld_q[1] &&
                   (cif.edge_rise ? (sync2_q && !prev_q) : (!sync2_q && prev_q));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'h0;
      end else if (cif.halt && edge_w) begin
         armed_q <= 1'h1;
      end else if (cif.halt_exit) begin
         armed_q <= 1'h0;
      end
   end

   assign cif.fire = (edge_w && !cif.halt) || (cif.halt_exit && armed_q);
endmodule : tmr_capture

// [hdl/tmr_top.sv]
/*
 16-bit timer control slice: APB registers, counter, flags, shared
 interrupt, compare pins and low-power behaviour.
 Assumes cpu_wait, cpu_halt and cpu_int_mask come from pclk logic and
 that leaving halt without reset is a wake by a halt-capable interrupt.
*/
`timescale 1ns/10ps
`include "tmr_cfg.svh"
module tmr_top import tmr_pkg::*; (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output wire logic        pready,
   output wire logic        pslverr,
   // Processor state
   input  wire logic        cpu_wait,
   input  wire logic        cpu_halt,
   input  wire logic        cpu_int_mask,
   output wire logic        timer_irq,
   output wire logic        wake_from_wait,
   // Capture and compare pins
   input  wire logic        cap_pin_one,
   input  wire logic        cap_pin_two,
   output logic             cmp_pin_one,
   output wire logic        cmp_pin_one_oe,
   output logic             cmp_pin_two,
   output wire logic        cmp_pin_two_oe
);
   logic [7:0] cr1_q;
   logic [7:0] cr2_q;
   logic [4:0] flag_q;
   logic [4:0] arm_q;
   logic       halt_q;
   tmr_word_t  cnt_q;
   tmr_word_t  ic1_q;
   tmr_word_t  ic2_q;
   tmr_word_t  oc1_q;
   tmr_word_t  oc2_q;
   logic [31:0] rd_d;
   logic [4:0] set_v;
   logic [4:0] clr_v;
   logic [4:0] en_v;
   logic       acc;
   logic       wr;
   logic       mapped;
   logic       halt_exit;
   logic       tick;
   logic       m1;
   logic       m2;
   logic       ovf;
   tmr_mode_e  mode;

   tmr_cap_if cap1_if ();
   tmr_cap_if cap2_if ();

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction : hit

   // APB: zero wait states; read data is sampled in the setup cycle.
   assign acc     = psel && penable;
   assign wr      = acc && pwrite && !cpu_halt;
   assign pready  = 1'h1;
   assign mapped  = hit(paddr, `TMR_OFS_CR1) || hit(paddr, `TMR_OFS_CR2) ||
                    hit(paddr, `TMR_OFS_SR)  || hit(paddr, `TMR_OFS_IC1) ||
                    hit(paddr, `TMR_OFS_IC2) || hit(paddr, `TMR_OFS_OC1) ||
                    hit(paddr, `TMR_OFS_OC2) || hit(paddr, `TMR_OFS_CNT) ||
                    hit(paddr, `TMR_OFS_ACNT);
   assign pslverr = acc && !mapped;

   always_comb begin
      rd_d = 32'h0;
      case (paddr)
         `TMR_OFS_CR1:  rd_d = {24'h0, cr1_q};
         `TMR_OFS_CR2:  rd_d = {24'h0, cr2_q};
         `TMR_OFS_SR:   rd_d = {24'h0, flag_q, 3'h0};
         `TMR_OFS_IC1:  rd_d = {16'h0, ic1_q};
         `TMR_OFS_IC2:  rd_d = {16'h0, ic2_q};
         `TMR_OFS_OC1:  rd_d = {16'h0, oc1_q};
         `TMR_OFS_OC2:  rd_d = {16'h0, oc2_q};
         `TMR_OFS_CNT,
         `TMR_OFS_ACNT: rd_d = {16'h0, cnt_q};
         default:       rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= rd_d;
      end
   end

   // Control registers; both reset to zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cr1_q <= `TMR_CR_RST;
         cr2_q <= `TMR_CR_RST;
      end else if (wr && hit(paddr, `TMR_OFS_CR1)) begin
         cr1_q <= pwdata[7:0];
      end else if (wr && hit(paddr, `TMR_OFS_CR2)) begin
         cr2_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc1_q <= `TMR_DAT_RST;
         oc2_q <= `TMR_DAT_RST;
      end else if (wr && hit(paddr, `TMR_OFS_OC1)) begin
         oc1_q <= pwdata[15:0];
      end else if (wr && hit(paddr, `TMR_OFS_OC2)) begin
         oc2_q <= pwdata[15:0];
      end
   end

   // PWM wins when both mode bits are set.
   always_comb begin
      if (cr2_q[`TMR_B_PWM]) begin
         mode = TMR_MD_PWM;
      end else if (cr2_q[`TMR_B_OPM]) begin
         mode = TMR_MD_OPM;
      end else begin
         mode = TMR_MD_NORM;
      end
   end

   // Halt exit without reset is taken as a wake by a halt-capable source.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_q <= 1'h0;
      end else begin
         halt_q <= cpu_halt;
      end
   end

   assign halt_exit = halt_q && !cpu_halt;

   tmr_div u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (!cpu_halt),
      .tick    (tick)
   );

   assign cap1_if.edge_rise = cr1_q[`TMR_B_CAPTURE_ONE_EDGE_SELECT];
   assign cap1_if.halt      = cpu_halt;
   assign cap1_if.halt_exit = halt_exit;
   assign cap2_if.edge_rise = cr2_q[`TMR_B_IEDG2];
   assign cap2_if.halt      = cpu_halt;
   assign cap2_if.halt_exit = halt_exit;

   tmr_capture u_cap1 (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (cap_pin_one),
      .cif     (cap1_if.cap)
   );

   tmr_capture u_cap2 (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (cap_pin_two),
      .cif     (cap2_if.cap)
   );

   assign m1  = tick && (cnt_q == oc1_q);
   assign m2  = tick && (cnt_q == oc2_q);
   assign ovf = tick && (cnt_q == `TMR_CNT_MAX) && !(mode == TMR_MD_PWM && m2);

   // Counter; after halt only presetn, or in OPM a capture armed during halt, brings back the reset value.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= `TMR_CNT_RST;
      end else if (mode == TMR_MD_OPM && cap1_if.fire) begin
         cnt_q <= `TMR_CNT_RST;
      end else if (mode == TMR_MD_PWM && m2) begin
         cnt_q <= `TMR_CNT_RST;
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // IC2, and IC1 in normal mode, take the count present at the capture or at wake.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ic1_q <= `TMR_DAT_RST;
      end else if (cap1_if.fire) begin
         unique case (mode)
            TMR_MD_NORM: ic1_q <= cnt_q;
            TMR_MD_OPM:  ic1_q <= `TMR_OPM_CAP;
            TMR_MD_PWM:  ic1_q <= ic1_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ic2_q <= `TMR_DAT_RST;
      end else if (cap2_if.fire) begin
         ic2_q <= cnt_q;
      end
   end

   // Flag sources; a forced output suppresses its compare flag.
   assign set_v[`TMR_F_CAPTURE_ONE_FLAG] = (mode == TMR_MD_PWM) ? m2 : cap1_if.fire;
   assign set_v[`TMR_F_COMPARE_ONE_FLAG] = m1 && mode == TMR_MD_NORM && !cr1_q[`TMR_B_FORCE_LEVEL_ONE];
   assign set_v[`TMR_F_TOF]  = ovf;
   assign set_v[`TMR_F_CAPTURE_TWO_FLAG] = cap2_if.fire;
   assign set_v[`TMR_F_COMPARE_TWO_FLAG] = m2 && mode != TMR_MD_PWM &&
                               !(mode == TMR_MD_NORM && cr1_q[`TMR_B_FORCE_LEVEL_TWO]);

   // Any access to the flag's data word completes the clear; for TOF only CNT does, an ACNT access does not.
   assign clr_v[`TMR_F_CAPTURE_ONE_FLAG] = arm_q[`TMR_F_CAPTURE_ONE_FLAG] && acc && hit(paddr, `TMR_OFS_IC1);
   assign clr_v[`TMR_F_COMPARE_ONE_FLAG] = arm_q[`TMR_F_COMPARE_ONE_FLAG] && acc && hit(paddr, `TMR_OFS_OC1);
   assign clr_v[`TMR_F_TOF]  = arm_q[`TMR_F_TOF]  && acc && hit(paddr, `TMR_OFS_CNT);
   assign clr_v[`TMR_F_CAPTURE_TWO_FLAG] = arm_q[`TMR_F_CAPTURE_TWO_FLAG] && acc && hit(paddr, `TMR_OFS_IC2);
   assign clr_v[`TMR_F_COMPARE_TWO_FLAG] = arm_q[`TMR_F_COMPARE_TWO_FLAG] && acc && hit(paddr, `TMR_OFS_OC2);

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 5'h00;
      end else begin
         flag_q <= set_v | (flag_q & ~clr_v);
      end
   end

   // Arming uses the status value software actually saw.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_q <= 5'h00;
      end else if (acc && !pwrite && hit(paddr, `TMR_OFS_SR)) begin
         arm_q <= (arm_q | prdata[7:3]) & ~clr_v;
      end else begin
         arm_q <= arm_q & ~clr_v;
      end
   end

   assign en_v = {cr1_q[`TMR_B_CIE], cr1_q[`TMR_B_OIE], cr1_q[`TMR_B_TIE],
                  cr1_q[`TMR_B_CIE], cr1_q[`TMR_B_OIE]};
   // The request is not a halt wake source; only wait sees it.
   assign timer_irq      = !cpu_int_mask && |(flag_q & en_v);
   assign wake_from_wait = timer_irq && cpu_wait;

   // Compare pin one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_pin_one <= 1'h0;
      end else begin
         unique case (mode)
            TMR_MD_NORM: if (cr1_q[`TMR_B_FORCE_LEVEL_ONE] || m1) begin
               cmp_pin_one <= cr1_q[`TMR_B_LEVEL_ONE_BIT];
            end
            TMR_MD_OPM:  if (cap1_if.fire) begin
               cmp_pin_one <= cr1_q[`TMR_B_LEVEL_TWO_BIT];
            end else if (m1) begin
               cmp_pin_one <= cr1_q[`TMR_B_LEVEL_ONE_BIT];
            end
            TMR_MD_PWM:  if (m2) begin
               cmp_pin_one <= cr1_q[`TMR_B_LEVEL_TWO_BIT];
            end else if (m1) begin
               cmp_pin_one <= cr1_q[`TMR_B_LEVEL_ONE_BIT];
            end
         endcase
      end
   end

   // Compare pin two carries no waveform in the pulse modes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_pin_two <= 1'h0;
      end else if (mode == TMR_MD_NORM && (cr1_q[`TMR_B_FORCE_LEVEL_TWO] || m2)) begin
         cmp_pin_two <= cr1_q[`TMR_B_LEVEL_TWO_BIT];
      end
   end

   assign cmp_pin_one_oe = cr2_q[`TMR_B_COMPARE_PIN_ONE_ENABLE];
   assign cmp_pin_two_oe = cr2_q[`TMR_B_COMPARE_PIN_TWO_ENABLE];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_wait_wake;
      (flag_q[`TMR_F_TOF] && cr1_q[`TMR_B_TIE] && !cpu_int_mask && cpu_wait)
         |-> wake_from_wait;
   endproperty
   a_wait_wake: assert property (p_wait_wake) else $error("no wake from wait");

   property p_mask;
      cpu_int_mask |-> !timer_irq && !wake_from_wait;
   endproperty
   a_mask: assert property (p_mask) else $error("masked request seen");

   property p_halt_freeze;
      cpu_halt ##1 cpu_halt |-> $stable(cnt_q) && $stable(ic1_q) && $stable(cr1_q);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze) else $error("halt not frozen");

   property p_resume;
      ($fell(cpu_halt) && mode != TMR_MD_OPM) |-> $stable(cnt_q);
   endproperty
   a_resume: assert property (p_resume) else $error("count lost at wake");

   property p_cap_wake;
      ($fell(cpu_halt) && cap1_if.fire && mode == TMR_MD_NORM)
         |=> flag_q[`TMR_F_CAPTURE_ONE_FLAG] && ic1_q == $past(cnt_q);
   endproperty
   a_cap_wake: assert property (p_cap_wake) else $error("wake capture wrong");

   property p_ovf;
      (tick && cnt_q == `TMR_CNT_MAX && mode == TMR_MD_NORM)
         |=> flag_q[`TMR_F_TOF] && cnt_q == 16'h0000;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow missed");

   property p_pwm_reload;
      (mode == TMR_MD_PWM && m2) |=> cnt_q == `TMR_CNT_RST && flag_q[`TMR_F_CAPTURE_ONE_FLAG];
   endproperty
   a_pwm_reload: assert property (p_pwm_reload) else $error("pwm reload wrong");

   property p_pwm_nocmp;
      mode == TMR_MD_PWM
         |=> !$rose(flag_q[`TMR_F_COMPARE_ONE_FLAG]) && !$rose(flag_q[`TMR_F_COMPARE_TWO_FLAG]);
   endproperty
   a_pwm_nocmp: assert property (p_pwm_nocmp) else $error("pwm compare flag");

   property p_force1;
      (mode == TMR_MD_NORM && cr1_q[`TMR_B_FORCE_LEVEL_ONE])
         |=> cmp_pin_one == $past(cr1_q[`TMR_B_LEVEL_ONE_BIT]);
   endproperty
   a_force1: assert property (p_force1) else $error("force one ignored");

   property p_cmp2;
      (mode == TMR_MD_NORM && m2) |=> cmp_pin_two == $past(cr1_q[`TMR_B_LEVEL_TWO_BIT]);
   endproperty
   a_cmp2: assert property (p_cmp2) else $error("pin two not updated");

   sequence s_sr_seen;
      acc && !pwrite && hit(paddr, `TMR_OFS_SR) && prdata[7];
   endsequence
   sequence s_ic1_touch;
      acc && hit(paddr, `TMR_OFS_IC1) && !set_v[`TMR_F_CAPTURE_ONE_FLAG];
   endsequence
   property p_clear;
      s_sr_seen ##[2:8] s_ic1_touch |=> !flag_q[`TMR_F_CAPTURE_ONE_FLAG];
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule : tmr_top

// [dv/tmr_pin_model.sv]
/*
 Pin-side model of the capture sources that face the timer.
 Assumes pclk is the timer clock and that the caller holds each level
 long enough to pass the capture synchroniser.
*/
`timescale 1ns/10ps
module tmr_pin_model (
   // Clock
   input  wire logic pclk,
   // Capture pins
   output logic      cap_pin_one,
   output logic      cap_pin_two
);
   // Pins idle high, so the first edge a test makes is a falling one.
   initial begin
      cap_pin_one = 1'b1;
      cap_pin_two = 1'b1;
   end
   task automatic drive(input logic sel_two, input logic level);
      @(posedge pclk);
      if (sel_two) begin
         cap_pin_two <= level;
      end else begin
         cap_pin_one <= level;
      end
   endtask : drive
endmodule : tmr_pin_model

// [dv/tmr_top_tb_top.sv]
/*
 Self-checking bench of the timer control slice: APB master, read scoreboard,
 interrupt, low-power, capture and compare-pin scenarios.
 Assumes tmr_pin_model drives the capture pins and the design's offsets header.
*/
`timescale 1ns/10ps
`include "tmr_cfg.svh"
module tmr_top_tb_top;
   localparam logic [32:0] ALL  = 33'h1FFFFFFFF;
   localparam logic [32:0] NONE = 33'h000000000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        cpu_wait, cpu_halt, cpu_int_mask, timer_irq, wake_from_wait;
   logic        cap_pin_one, cap_pin_two, cmp_pin_one, cmp_pin_two;
   logic        cmp_pin_one_oe, cmp_pin_two_oe;
   logic [32:0] exp_q[$];
   logic [32:0] msk_q[$];
   logic [32:0] mon_m;
   logic [7:0]  seed;
   int          errors;
   int          n_tests;

   tmr_top tmr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
      .cpu_int_mask(cpu_int_mask), .timer_irq(timer_irq), .wake_from_wait(wake_from_wait),
      .cap_pin_one(cap_pin_one), .cap_pin_two(cap_pin_two), .cmp_pin_one(cmp_pin_one),
      .cmp_pin_one_oe(cmp_pin_one_oe), .cmp_pin_two(cmp_pin_two),
      .cmp_pin_two_oe(cmp_pin_two_oe));
   tmr_pin_model tmr_pin_model_i (.pclk(pclk), .cap_pin_one(cap_pin_one),
      .cap_pin_two(cap_pin_two));

   always #25 pclk = ~pclk;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [32:0] seen, input logic [32:0] want);
      n_tests++;
      if (seen !== want) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : chk

   task automatic chk1(input logic seen, input logic want);
      chk({32'h0, seen}, {32'h0, want});
   endtask : chk1

   // Every drive starts just after a rising edge, so one idle cycle separates transfers.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         errors++;
         print_verdict();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      apb(a, 1'b0, 32'h0);
   endtask : rd

   // The status read must show the flag being cleared, or the clear is not armed.
   task automatic clr(input logic [7:0] a, input logic [32:0] f);
      rd(`TMR_OFS_SR, f, f);
      rd(a, NONE, NONE);
   endtask : clr

   task automatic wait_irq(input logic v, input int lim);
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (timer_irq !== v && k < lim);
      chk1(timer_irq, v);
      if (timer_irq !== v) begin
         print_verdict();
      end
   endtask : wait_irq

   task automatic stay0(input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(negedge pclk);
         if (timer_irq !== 1'b0) bad = 1'b1;
      end
      chk1(bad, 1'b0);
   endtask : stay0

   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : do_reset

   // Read data and the error flag are judged at the access edge, oldest note first.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (exp_q.size() == 0) begin
            chk(ALL, NONE);
         end else begin
            mon_m = msk_q.pop_front();
            chk({pslverr, prdata} & mon_m, exp_q.pop_front());
         end
      end
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {cpu_wait, cpu_halt, cpu_int_mask} = 3'h0;
      errors = 0;
      n_tests = 0;
      do_reset();
      rd(`TMR_OFS_CR1, NONE, ALL);
      rd(8'hFC, {1'b1, 32'h0}, ALL);
      seed = 8'h09;
      repeat (4) begin
         seed = lfsr(seed);
         wr(`TMR_OFS_CR1, {24'h0, seed});
         rd(`TMR_OFS_CR1, {25'h0, seed}, ALL);
      end
      $display("Test registers finished");
      do_reset();
      wr(`TMR_OFS_CR1, 32'h20);
      @(posedge pclk);
      cpu_halt <= 1'b1;
      wr(`TMR_OFS_CR1, 32'hFF);
      rd(`TMR_OFS_CR1, 33'h20, ALL);
      stay0(100);
      @(posedge pclk);
      cpu_wait <= 1'b1;
      cpu_halt <= 1'b0;
      wait_irq(1'b1, 60);
      chk1(wake_from_wait, 1'b1);
      @(posedge pclk);
      cpu_int_mask <= 1'b1;
      wait_irq(1'b0, 2);
      @(posedge pclk);
      cpu_int_mask <= 1'b0;
      wr(`TMR_OFS_CR1, 32'h00);
      wait_irq(1'b0, 2);
      wr(`TMR_OFS_CR1, 32'h20);
      clr(`TMR_OFS_ACNT, 33'h20);
      wait_irq(1'b1, 2);
      clr(`TMR_OFS_CNT, 33'h20);
      wait_irq(1'b0, 3);
      @(posedge pclk);
      cpu_wait <= 1'b0;
      cpu_halt <= 1'b1;
      do_reset();
      rd(`TMR_OFS_CNT, 33'hFFFC, ALL);
      @(posedge pclk);
      cpu_halt <= 1'b0;
      $display("Test overflow and halt finished");
      wr(`TMR_OFS_CR1, 32'h82);
      tmr_pin_model_i.drive(1'b0, 1'b0);
      stay0(20);
      tmr_pin_model_i.drive(1'b0, 1'b1);
      wait_irq(1'b1, 20);
      clr(`TMR_OFS_IC1, 33'h80);
      wait_irq(1'b0, 3);
      wr(`TMR_OFS_CR1, 32'h00);
      tmr_pin_model_i.drive(1'b0, 1'b0);
      stay0(20);
      wr(`TMR_OFS_CR1, 32'h82);
      wait_irq(1'b1, 3);
      clr(`TMR_OFS_IC1, 33'h80);
      @(posedge pclk);
      cpu_halt <= 1'b1;
      tmr_pin_model_i.drive(1'b0, 1'b1);
      tmr_pin_model_i.drive(1'b1, 1'b0);
      stay0(30);
      @(posedge pclk);
      cpu_halt <= 1'b0;
      wait_irq(1'b1, 20);
      chk1(wake_from_wait, 1'b0);
      chk1(cmp_pin_one_oe, 1'b0);
      $display("Test capture finished");
      do_reset();
      wr(`TMR_OFS_CR2, 32'hC0);
      wr(`TMR_OFS_OC1, 32'h0020);
      wr(`TMR_OFS_OC2, 32'h0030);
      wr(`TMR_OFS_CR1, 32'h45);
      wait_irq(1'b1, 400);
      repeat (2) @(negedge pclk);
      chk1(cmp_pin_one, 1'b1);
      chk1(cmp_pin_two, 1'b0);
      clr(`TMR_OFS_OC1, 33'h40);
      wait_irq(1'b0, 3);
      wait_irq(1'b1, 200);
      repeat (2) @(negedge pclk);
      chk1(cmp_pin_two, 1'b1);
      clr(`TMR_OFS_OC2, 33'h08);
      wr(`TMR_OFS_CR1, 32'h08);
      repeat (3) @(negedge pclk);
      chk1(cmp_pin_one, 1'b0);
      chk1(cmp_pin_one_oe, 1'b1);
      wr(`TMR_OFS_CR1, 32'h10);
      repeat (3) @(negedge pclk);
      chk1(cmp_pin_two, 1'b0);
      chk1(cmp_pin_two_oe, 1'b1);
      $display("Test compare finished");
      do_reset();
      wr(`TMR_OFS_OC2, 32'h0030);
      wr(`TMR_OFS_OC1, 32'h0010);
      wr(`TMR_OFS_CR2, 32'h90);
      wr(`TMR_OFS_CR1, 32'h40);
      stay0(300);
      chk1(cmp_pin_two_oe, 1'b0);
      wr(`TMR_OFS_CR1, 32'h84);
      wait_irq(1'b1, 3);
      clr(`TMR_OFS_IC1, 33'h80);
      wait_irq(1'b0, 3);
      wait_irq(1'b1, 300);
      repeat (2) @(negedge pclk);
      chk1(cmp_pin_one, 1'b1);
      $display("Test pulse width finished");
      do_reset();
      wr(`TMR_OFS_CR2, 32'hA0);
      wr(`TMR_OFS_CR1, 32'h84);
      tmr_pin_model_i.drive(1'b0, 1'b0);
      wait_irq(1'b1, 20);
      chk1(cmp_pin_one, 1'b1);
      rd(`TMR_OFS_IC1, 33'hFFFD, ALL);
      repeat (24) @(negedge pclk);
      chk1(cmp_pin_one, 1'b0);
      $display("Test one pulse finished");
      print_verdict();
   end
endmodule : tmr_top_tb_top
